/* File: hw/flow_ctrl_defines.svh */
// timing counts and sizes for the pipeline flow controller
//
// Operation
// - final writeback pointer from address-stage adder, per-access from data-address adder
// - multi-register transfers run under their own decoupled state machine
// - updated base pointer usable one cycle after issue
// - pc load with empty return stack flushes pipeline, six-cycle penalty
// - long register lists hide the pc reload penalty
// - stall writers of registers still pending multi-register store
// - flags of load-multiple and pop usable two cycles after issue
// - first loaded word usable two cycles after issue
// - pc load also tests return-value register and sets flags
// - relative jump always taken, never mispredicted
// - calls push return address on four-entry return stack
// - predicted return pops stack top and redirects fetch there
// - every call writes link register, never zero cycles
// - relative calls predicted; indirect, memory, supervisor, breakpoint calls not
// - memory and application call targets used only from writeback
// - predicted relative call takes one or two cycles
// - exception returns unpredicted; target from address stage, fetched next
// - exception, debug and supervisor returns issue in four cycles
// - exchange reads then writes memory atomically
// - stall writers of exchange store register until store leaves data stage
// - exchange issue latency two, result latency three
`ifndef FLOW_CTRL_DEFINES_SVH
`define FLOW_CTRL_DEFINES_SVH

`define RAS_DEPTH        4
`define PTR_READY_CYC    1
`define LDM_DATA_CYC     2
`define LDM_FLAG_CYC     2
`define PC_FLUSH_CYC     6
`define RETX_ISSUE_CYC   4
`define XCHG_ISSUE_CYC   2
`define XCHG_RESULT_CYC  3
`define CNT_W            3

`endif

/* File: hw/flow_ctrl_pkg.sv */
// types for the pipeline flow controller
package flow_ctrl_pkg;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_LDM    = 4'h1,
    OP_POPM   = 4'h2,
    OP_STM    = 4'h3,
    OP_PUSHM  = 4'h4,
    OP_RJMP   = 4'h5,
    OP_RET    = 4'h6,
    OP_RCALL  = 4'h7,
    OP_ICALL  = 4'h8,
    OP_MCALL  = 4'h9,
    OP_ACALL  = 4'hA,
    OP_SCALL  = 4'hB,
    OP_BRK    = 4'hC,
    OP_RETX   = 4'hD,
    OP_XCHG   = 4'hE
  } op_t;

  // issued instruction as seen from the address stage
  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [15:0] regList;
    logic [31:0] base;
    logic [31:0] nextPc;
    logic [31:0] target;
    logic        compact;
    logic        aligned;
    logic [3:0]  storeReg;
  } issue_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  dstReg;
  } wreq_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        lock;
    logic [31:0] addr;
    logic [3:0]  reg_;
  } mem_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } redirect_t;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_RUN   = 3'b001,
    LS_LAST  = 3'b011,
    LS_XRD   = 3'b010,
    LS_XWR   = 3'b110
  } ls_state_t;

endpackage : flow_ctrl_pkg

/* File: hw/ret_stack.sv */
// four-entry return-address stack
`timescale 1ns/1ns
`include "flow_ctrl_defines.svh"
module ret_stack
  import flow_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        push,
  input  wire logic [31:0] pushAddr,
  input  wire logic        pop,
  output logic      [31:0] topAddr,
  output logic             empty
);

  typedef struct packed {
    logic [`RAS_DEPTH-1:0][31:0] ent;
    logic [2:0]                  cnt;
    logic [31:0]                 top;
  } ras_t;

  ras_t s;
  ras_t next_s;

  always_comb begin
    next_s = s;
    if (push) begin
      // shifting keeps the four newest and drops the oldest
      next_s.ent = {s.ent[`RAS_DEPTH-2:0], pushAddr};
      if (s.cnt != 3'h4)
        next_s.cnt = s.cnt + 3'h1;
    end else if (pop && s.cnt != 3'h0) begin
      next_s.ent = {32'h0, s.ent[`RAS_DEPTH-1:1]};
      next_s.cnt = s.cnt - 3'h1;
    end
    next_s.top = next_s.ent[0];
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign topAddr = s.top;
  assign empty   = (s.cnt == 3'h0);

endmodule : ret_stack

/* File: hw/flow_ctrl.sv */
// pipeline flow control: multi-transfer sequencer, prediction, latencies
`timescale 1ns/1ns
`include "flow_ctrl_defines.svh"
module flow_ctrl
  import flow_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  issue_t           issue,
  input  wreq_t            laterWrite,
  input  wire logic        memReady,
  input  wire logic [31:0] retValue,
  input  wire logic        wbTargetValid,
  input  wire logic [31:0] wbTarget,
  output logic             issueStall,
  output logic             writeStall,
  output mem_t             mem,
  output redirect_t        redirect,
  output logic             flush,
  output logic             linkWrite,
  output logic [31:0]      linkValue,
  output logic             ptrValid,
  output logic [31:0]      ptrValue,
  output logic             dataReady,
  output logic             flagReady,
  output logic [3:0]       flagsNzcv,
  output logic             resultReady
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ls_state_t   ls;
    logic [15:0] pend;
    logic [31:0] addr;
    logic        isLoad;
    logic        pcLoad;
    logic        pcFlush;
    logic [3:0]  xReg;
    logic [`CNT_W-1:0] issueCnt;
    logic [`CNT_W-1:0] resCnt;
    logic [`CNT_W-1:0] dataCnt;
    logic [`CNT_W-1:0] flagCnt;
    logic [`CNT_W-1:0] flushCnt;
    logic        waitWb;
    logic        issueStall;
    logic        writeStall;
    mem_t        mem;
    redirect_t   redirect;
    logic        flush;
    logic        linkWrite;
    logic [31:0] linkValue;
    logic        ptrValid;
    logic [31:0] ptrValue;
    logic        dataReady;
    logic        flagReady;
    logic [3:0]  flagsNzcv;
    logic        resultReady;
  } st_t;

  st_t s;
  st_t next_s;

  logic [31:0] rasTop;
  logic        rasEmpty;
  logic        rasPush;
  logic        rasPop;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] popCount(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h0;
    for (int i = 0; i < 16; i++)
      c = c + {4'h0, v[i]};
    return c;
  endfunction : popCount

  function automatic logic [3:0] lowestBit(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction : lowestBit

  function automatic logic [2:0] cnt(input int n);
    return 3'(n);
  endfunction : cnt

  ////////////////////////////////////////////////////////////////////////
  logic isMulti;
  logic isLoadM;
  logic isCall;
  logic [31:0] span;
  logic [3:0] curReg;

  always_comb begin
    isMulti = issue.valid && !s.issueStall &&
              (issue.op == OP_LDM || issue.op == OP_POPM ||
               issue.op == OP_STM || issue.op == OP_PUSHM);
    isLoadM = issue.op == OP_LDM || issue.op == OP_POPM;
    isCall  = issue.op == OP_RCALL || issue.op == OP_ICALL ||
              issue.op == OP_MCALL || issue.op == OP_ACALL ||
              issue.op == OP_SCALL || issue.op == OP_BRK;
    span    = {25'h0, popCount(issue.regList), 2'h0};
    curReg  = lowestBit(s.pend);
    rasPush = issue.valid && !s.issueStall && isCall;
    rasPop  = issue.valid && !s.issueStall && issue.op == OP_RET &&
              !rasEmpty;
  end

  always_comb begin
    next_s = s;
    next_s.redirect    = '0;
    next_s.flush       = 1'b0;
    next_s.linkWrite   = 1'b0;
    next_s.ptrValid    = 1'b0;
    next_s.dataReady   = 1'b0;
    next_s.flagReady   = 1'b0;
    next_s.resultReady = 1'b0;
    next_s.mem.req     = 1'b0;

    // countdowns
    if (s.issueCnt != '0) next_s.issueCnt = s.issueCnt - cnt(1);
    if (s.resCnt != '0) begin
      next_s.resCnt = s.resCnt - cnt(1);
      if (s.resCnt == cnt(1)) next_s.resultReady = 1'b1;
    end
    if (s.dataCnt != '0) begin
      next_s.dataCnt = s.dataCnt - cnt(1);
      if (s.dataCnt == cnt(1)) next_s.dataReady = 1'b1;
    end
    if (s.flagCnt != '0) begin
      next_s.flagCnt = s.flagCnt - cnt(1);
      if (s.flagCnt == cnt(1)) next_s.flagReady = 1'b1;
    end
    if (s.flushCnt != '0) next_s.flushCnt = s.flushCnt - cnt(1);

    // memory and application call targets only from writeback
    if (s.waitWb && wbTargetValid) begin
      next_s.redirect = '{valid: 1'b1, addr: wbTarget};
      next_s.waitWb   = 1'b0;
    end

    // issue side
    if (issue.valid && !s.issueStall) begin
      case (issue.op)
        OP_LDM, OP_POPM, OP_STM, OP_PUSHM: begin
          // address-stage adder gives the final pointer
          next_s.ptrValid = 1'b1;
          next_s.ptrValue = (issue.op == OP_STM || issue.op == OP_PUSHM) ?
                            issue.base - span : issue.base + span;
          next_s.pend   = issue.regList;
          next_s.addr   = (issue.op == OP_STM || issue.op == OP_PUSHM) ?
                          issue.base - span : issue.base;
          next_s.isLoad = isLoadM;
          next_s.pcLoad = isLoadM && issue.regList[15];
          // short lists expose the flush, long lists hide it
          next_s.pcFlush = isLoadM && issue.regList[15] && rasEmpty &&
                           popCount(issue.regList) <= 5'(`PC_FLUSH_CYC);
          next_s.ls     = LS_RUN;
          // the pulse register itself adds the final cycle
          if (isLoadM) begin
            next_s.dataCnt = cnt(`LDM_DATA_CYC - 1);
            next_s.flagCnt = cnt(`LDM_FLAG_CYC - 1);
          end
        end
        OP_RJMP: begin
          next_s.redirect = '{valid: 1'b1, addr: issue.target};
        end
        OP_RET: begin
          if (!rasEmpty)
            next_s.redirect = '{valid: 1'b1, addr: rasTop};
          else
            next_s.redirect = '{valid: 1'b1, addr: issue.target};
        end
        OP_RCALL, OP_ICALL, OP_MCALL, OP_ACALL, OP_SCALL, OP_BRK: begin
          next_s.linkWrite = 1'b1;
          next_s.linkValue = issue.nextPc;
          if (issue.op == OP_RCALL) begin
            next_s.redirect = '{valid: 1'b1, addr: issue.target};
            // misaligned or extended form costs the second cycle
            if (!(issue.compact && issue.aligned))
              next_s.issueCnt = cnt(1);
          end else if (issue.op == OP_MCALL || issue.op == OP_ACALL) begin
            next_s.waitWb = 1'b1;
          end else begin
            next_s.redirect = '{valid: 1'b1, addr: issue.target};
          end
        end
        OP_RETX: begin
          // target from address stage, fetch follows next cycle
          next_s.redirect = '{valid: 1'b1, addr: issue.target};
          next_s.issueCnt = cnt(`RETX_ISSUE_CYC - 1);
        end
        OP_XCHG: begin
          next_s.ls       = LS_XRD;
          next_s.addr     = issue.base;
          next_s.xReg     = issue.storeReg;
          next_s.issueCnt = cnt(`XCHG_ISSUE_CYC - 1);
          next_s.resCnt   = cnt(`XCHG_RESULT_CYC - 1);
        end
        default: begin
        end
      endcase
    end

    // decoupled load/store sequencer: advances on each accepted beat
    case (s.ls)
      LS_RUN, LS_LAST: begin
        if (memReady) begin
          next_s.pend = s.pend & ~(16'h1 << curReg);
          next_s.addr = s.addr + 32'h4;
          if (popCount(s.pend) == 5'h2)
            next_s.ls = LS_LAST;
          if (popCount(s.pend) == 5'h1) begin
            next_s.ls = LS_IDLE;
            if (s.pcLoad) begin
              next_s.flagsNzcv = {retValue[31], retValue == 32'h0,
                                  2'h0};
              next_s.flagReady = 1'b1;
              if (s.pcFlush) begin
                next_s.flush    = 1'b1;
                next_s.flushCnt = cnt(`PC_FLUSH_CYC);
              end
            end
          end
        end
      end
      LS_XRD: begin
        if (memReady) next_s.ls = LS_XWR;
      end
      LS_XWR: begin
        if (memReady) next_s.ls = LS_IDLE;
      end
      LS_IDLE: begin
        // keeps whatever the issue side has started this cycle
      end
      default: begin
        next_s.ls = LS_IDLE;
      end
    endcase
    if (isMulti) next_s.ls = LS_RUN;

    // the request register shows the beat the next state points at,
    // so an accepted beat is never presented a second time
    case (next_s.ls)
      LS_RUN, LS_LAST: begin
        next_s.mem = '{req: 1'b1, write: !next_s.isLoad, lock: 1'b0,
                       addr: next_s.addr,
                       reg_: lowestBit(next_s.pend)};
      end
      LS_XRD: begin
        next_s.mem = '{req: 1'b1, write: 1'b0, lock: 1'b1,
                       addr: next_s.addr, reg_: next_s.xReg};
      end
      LS_XWR: begin
        next_s.mem = '{req: 1'b1, write: 1'b1, lock: 1'b1,
                       addr: next_s.addr, reg_: next_s.xReg};
      end
      default: begin
        next_s.mem.req = 1'b0;
      end
    endcase

    // issue blocked only by multi-cycle issue, flush or a busy sequencer
    next_s.issueStall = next_s.issueCnt != '0 ||
                        next_s.flushCnt != '0 ||
                        (next_s.ls != LS_IDLE && issue.valid &&
                         (issue.op == OP_LDM || issue.op == OP_POPM ||
                          issue.op == OP_STM || issue.op == OP_PUSHM ||
                          issue.op == OP_XCHG));
    // write-after-read hazard against pending stores
    next_s.writeStall = laterWrite.valid &&
      ((next_s.ls inside {LS_RUN, LS_LAST} && !next_s.isLoad &&
        next_s.pend[laterWrite.dstReg]) ||
       (next_s.ls inside {LS_XRD, LS_XWR} &&
        laterWrite.dstReg == next_s.xReg));
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////
  ret_stack u_ret_stack (
    .clk      (clk),
    .rst_b    (rst_b),
    .push     (rasPush),
    .pushAddr (issue.nextPc),
    .pop      (rasPop),
    .topAddr  (rasTop),
    .empty    (rasEmpty)
  );

  assign issueStall  = s.issueStall;
  assign writeStall  = s.writeStall;
  assign mem         = s.mem;
  assign redirect    = s.redirect;
  assign flush       = s.flush;
  assign linkWrite   = s.linkWrite;
  assign linkValue   = s.linkValue;
  assign ptrValid    = s.ptrValid;
  assign ptrValue    = s.ptrValue;
  assign dataReady   = s.dataReady;
  assign flagReady   = s.flagReady;
  assign flagsNzcv   = s.flagsNzcv;
  assign resultReady = s.resultReady;

endmodule : flow_ctrl

/* File: bench/flow_ctrl_sva.sv */
// port assertions for the pipeline flow controller
`timescale 1ns/1ns
module flow_ctrl_sva
  import flow_ctrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input issue_t           issue,
  input wire logic        issueStall,
  input mem_t             mem,
  input wire logic        memReady,
  input redirect_t        redirect,
  input wire logic        flush,
  input wire logic        linkWrite,
  input wire logic [31:0] linkValue,
  input wire logic        ptrValid,
  input wire logic        dataReady,
  input wire logic        flagReady,
  input wire logic        resultReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic multi;
  logic load;
  logic call;
  assign tk = issue.valid && !issueStall;
  assign multi = issue.op inside {OP_LDM, OP_POPM, OP_STM, OP_PUSHM};
  assign load = issue.op inside {OP_LDM, OP_POPM};
  assign call = issue.op inside {OP_RCALL, OP_ICALL, OP_MCALL, OP_ACALL,
                                 OP_SCALL, OP_BRK};
  ////////////////////////////////////////////////////////////////////////
  property p_ptr; tk && multi |=> ptrValid; endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer update late");
  property p_data; tk && load |-> ##2 dataReady; endproperty
  a_data: assert property (p_data)
    else $error("first word not ready after two cycles");
  property p_flag; tk && load |-> ##2 flagReady; endproperty
  a_flag: assert property (p_flag)
    else $error("flags not ready after two cycles");
  property p_res; tk && issue.op == OP_XCHG |-> ##3 resultReady; endproperty
  a_res: assert property (p_res)
    else $error("exchange result not ready after three cycles");
  property p_link;
    tk && call |=> linkWrite && linkValue == $past(issue.nextPc);
  endproperty
  a_link: assert property (p_link)
    else $error("call did not write link register");
  property p_rjmp; tk && issue.op == OP_RJMP |=> !flush [*3]; endproperty
  a_rjmp: assert property (p_rjmp)
    else $error("relative jump flushed");
  property p_retx;
    tk && issue.op == OP_RETX |=>
      redirect.valid && redirect.addr == $past(issue.target);
  endproperty
  a_retx: assert property (p_retx)
    else $error("exception return not redirected next cycle");
  property p_retx_stall;
    tk && issue.op == OP_RETX |=> issueStall [*3] ##1 !issueStall;
  endproperty
  a_retx_stall: assert property (p_retx_stall)
    else $error("exception return issue latency wrong");
  property p_rcall;
    tk && issue.op == OP_RCALL && issue.compact && issue.aligned
      |=> !issueStall;
  endproperty
  a_rcall: assert property (p_rcall)
    else $error("short relative call stalled");
  property p_xchg;
    mem.req && mem.lock && !mem.write && memReady |=> mem.req && mem.write;
  endproperty
  a_xchg: assert property (p_xchg)
    else $error("exchange write did not follow read");
endmodule : flow_ctrl_sva

bind flow_ctrl flow_ctrl_sva u_flow_ctrl_sva (
  .clk(clk), .rst_b(rst_b), .issue(issue), .issueStall(issueStall),
  .mem(mem), .memReady(memReady), .redirect(redirect), .flush(flush),
  .linkWrite(linkWrite), .linkValue(linkValue), .ptrValid(ptrValid),
  .dataReady(dataReady), .flagReady(flagReady), .resultReady(resultReady)
);

/* File: bench/data_mem_model.sv */
// data memory partner: answers at once or after two wait cycles
`timescale 1ns/1ns
module data_mem_model
  import flow_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic slow,
  input  mem_t      mem,
  output logic      memReady
);
  logic [1:0] waitCnt;
  always_ff @(posedge clk) begin
    if (!rst_b || !mem.req || memReady) waitCnt <= 2'h0;
    else waitCnt <= waitCnt + 2'h1;
  end
  // slow mode keeps stores pending long enough to expose hazards
  assign memReady = mem.req && (!slow || waitCnt == 2'h2);
endmodule : data_mem_model

/* File: bench/cpu_pipeline_flow_timing_bench.sv */
// self-checking bench for the pipeline flow controller
`timescale 1ns/1ns
module cpu_pipeline_flow_timing_bench
  import flow_ctrl_pkg::*;
;
  typedef struct packed {
    op_t op; logic [15:0] regs; logic cmp;
    logic [3:0] ptr, dat, res, lnk, rdr, stl; logic fl;
  } row_t;
  logic clk, rst_b, slow, memReady, wbTargetValid;
  logic [31:0] retValue, wbTarget, linkValue, ptrValue, pV, gV;
  issue_t issue;
  wreq_t laterWrite;
  mem_t mem;
  redirect_t redirect;
  logic issueStall, writeStall, flush, linkWrite, ptrValid;
  logic dataReady, flagReady, resultReady, fS, w2, w12;
  logic [3:0] flagsNzcv, fV, pA, dA, rA, lA, gA, sN;
  int failures, n_checks;
  localparam logic [3:0] X = 4'hF;
  row_t rows [15] = '{
    '{OP_LDM, 16'h8003, 1'b1, 4'h1, 4'h2, 4'h0, 4'h0, X, X, 1'b1},
    '{OP_LDM, 16'h81FF, 1'b1, 4'h1, 4'h2, 4'h0, 4'h0, X, X, 1'b0},
    '{OP_POPM, 16'h0003, 1'b1, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0, X, 1'b0},
    '{OP_STM, 16'h0003, 1'b1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, X, 1'b0},
    '{OP_PUSHM, 16'h0001, 1'b1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, X, 1'b0},
    '{OP_RJMP, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, X, 1'b0},
    '{OP_RCALL, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 1'b0},
    '{OP_RCALL, 16'h0, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1, X, 4'h1, 1'b0},
    '{OP_ICALL, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, X, X, 1'b0},
    '{OP_SCALL, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, X, X, 1'b0},
    '{OP_BRK, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, X, X, 1'b0},
    '{OP_MCALL, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, X, 1'b0},
    '{OP_ACALL, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, X, 1'b0},
    '{OP_RETX, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h3, 1'b0},
    '{OP_XCHG, 16'h0, 1'b1, 4'h0, 4'h0, 4'h3, 4'h0, 4'h0, 4'h1, 1'b0}};
  flow_ctrl u_flow_ctrl (.clk(clk), .rst_b(rst_b), .issue(issue),
    .laterWrite(laterWrite), .memReady(memReady), .retValue(retValue),
    .wbTargetValid(wbTargetValid), .wbTarget(wbTarget),
    .issueStall(issueStall), .writeStall(writeStall), .mem(mem),
    .redirect(redirect), .flush(flush), .linkWrite(linkWrite),
    .linkValue(linkValue), .ptrValid(ptrValid), .ptrValue(ptrValue),
    .dataReady(dataReady), .flagReady(flagReady), .flagsNzcv(flagsNzcv),
    .resultReady(resultReady));
  data_mem_model u_data_mem_model (.clk(clk), .rst_b(rst_b), .slow(slow),
    .mem(mem), .memReady(memReady));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // issue one instruction, then log when each answer shows up
  task automatic run(row_t r, logic [31:0] np, logic [3:0] sr);
    int n;
    @(posedge clk);
    issue <= '{1'b1, r.op, r.regs, 32'h0000_0100, np, 32'h0000_BEEF,
               r.cmp, 1'b1, sr};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (issueStall && n < 20);
    if (n == 20) begin
      failures++;
      results();
    end
    @(posedge clk);
    issue.valid <= 1'b0;
    {pA, dA, rA, lA, gA, sN, fS} = '0;
    for (logic [3:0] c = 4'h1; c < 4'hD; c++) begin
      @(negedge clk);
      if (ptrValid && pA == 4'h0) {pA, pV} = {c, ptrValue};
      if (dataReady && dA == 4'h0) dA = c;
      if (flagReady) fV = flagsNzcv;
      if (resultReady && rA == 4'h0) rA = c;
      if (linkWrite && lA == 4'h0) lA = c;
      if (redirect.valid && gA == 4'h0) {gA, gV} = {c, redirect.addr};
      if (issueStall) sN++;
      if (flush) fS = 1'b1;
      if (c == 4'h2) w2 = writeStall;
      if (c == 4'hC) w12 = writeStall;
    end
  endtask : run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_b, slow, wbTargetValid, wbTarget, retValue} = '0;
    issue = '0;
    laterWrite = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i], 32'h0000_2000, 4'h4);
      chk(pA, rows[i].ptr);
      chk(dA, rows[i].dat);
      chk(rA, rows[i].res);
      chk(lA, rows[i].lnk);
      if (rows[i].rdr != X) chk(gA, rows[i].rdr);
      if (rows[i].stl != X) chk(sN, rows[i].stl);
      chk(fS, rows[i].fl);
      if (rows[i].regs[15]) chk(fV, 4'h4);
      if (rows[i].op == OP_LDM)
        chk(pV, 32'h100 + 4 * $countones(rows[i].regs));
    end
    // a memory call waits for its target from the writeback stage
    run(rows[11], 32'h0000_2000, 4'h0);
    chk(redirect.valid, 1'b0);
    @(posedge clk);
    wbTarget <= 32'h0000_4000;
    wbTargetValid <= 1'b1;
    @(posedge clk);
    wbTargetValid <= 1'b0;
    @(negedge clk);
    chk(redirect.valid, 1'b1);
    chk(redirect.addr, 32'h0000_4000);
    // five calls overfill the stack; the oldest must be lost
    for (int i = 0; i < 5; i++) run(rows[6], 32'h1000 + i * 16, 4'h0);
    for (int i = 4; i >= 0; i--) begin
      run('{OP_RET, 16'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0, X, X, 1'b0},
          32'h0, 4'h0);
      chk(gV, i > 0 ? 32'h1000 + i * 16 : 32'hBEEF);
    end
    @(posedge clk);
    slow <= 1'b1;
    laterWrite <= '{1'b1, 4'h1};
    run(rows[3], 32'h0, 4'h0);
    chk(w2, 1'b1);
    chk(w12, 1'b0);
    @(posedge clk);
    laterWrite <= '{1'b1, 4'h4};
    run(rows[14], 32'h0, 4'h4);
    chk(w2, 1'b1);
    chk(w12, 1'b0);
    results();
  end
endmodule : cpu_pipeline_flow_timing_bench
